// ---- src/sap_pkg.sv ----
// Package for the serial audio port FIFO/DMA control block
// Assumes a single register port with byte offset addressing
package sap_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SAP_OFS_MODE = 8'h0C;
  localparam logic [7:0] SAP_OFS_BRG  = 8'h14;
  localparam logic [7:0] SAP_OFS_DMA  = 8'h18;
  localparam logic [7:0] SAP_OFS_AUD  = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SAP_MODE_SSV   = 0;
  localparam int SAP_MODE_SSIO  = 1;
  localparam int SAP_DMA_TXLVL  = 0;
  localparam int SAP_DMA_TXCLR  = 4;
  localparam int SAP_DMA_TXCNT  = 8;
  localparam int SAP_DMA_TXEN   = 15;
  localparam int SAP_DMA_RXLVL  = 16;
  localparam int SAP_DMA_RXCLR  = 20;
  localparam int SAP_DMA_RXCNT  = 24;
  localparam int SAP_DMA_RXEN   = 31;
  localparam int SAP_AUD_EN     = 0;
  localparam int SAP_AUD_MUTE   = 1;
  localparam int SAP_AUD_PAUSE  = 2;
  localparam int SAP_AUD_MONO   = 3;
  localparam int SAP_AUD_JUST   = 4;
  localparam int SAP_BRG_W      = 16;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [31:0] SAP_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] SAP_BRG_MIN  = 16'h0002;

  typedef struct packed {
    logic        en;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sap_req_t;

  typedef enum logic [1:0] {
    SAP_IDLE = 2'b00,
    SAP_LEFT = 2'b01,
    SAP_RIGHT = 2'b11
  } sap_state_t;

endpackage : sap_pkg

// ---- src/sap_top.sv ----
// Serial audio port: select pin, bit rate, FIFO/DMA control and audio framing
// Assumes a simple synchronous register port and an external bit clock pin
`timescale 1ns/1ns

module sap_top #(
  parameter int DEPTH = 8,
  parameter int WORD  = 16
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire sap_pkg::sap_req_t reg_req,
  output logic [31:0]            reg_rdata,
  input  wire logic              master_en,
  input  wire logic              tx_push,
  input  wire logic [WORD-1:0]   tx_data,
  output logic [WORD-1:0]        rx_data,
  input  wire logic              rx_pop,
  input  wire logic              bit_clk,
  input  wire logic              ser_in,
  output logic                   ser_out,
  input  wire logic              select_pin_i,
  output logic                   select_pin_o,
  output logic                   select_pin_oe,
  output logic                   tx_dma_req,
  output logic                   rx_dma_req
);

  initial begin
    if (DEPTH != 8 || WORD < 2 || WORD > 16) begin
      $error("sap_top: DEPTH must be 8 and WORD 2..16");
    end
  end

  // ----------------------------------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------------------------------
  logic       rs1_reg, rst_n;
  logic [2:0] in_s1_reg, in_s2_reg;
  logic       bclk_d_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs1_reg <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n   <= rs1_reg;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_reg  <= 3'h0;
      in_s2_reg  <= 3'h0;
      bclk_d_reg <= 1'b0;
    end else if (ce) begin
      in_s1_reg  <= {select_pin_i, ser_in, bit_clk};
      in_s2_reg  <= in_s1_reg;
      bclk_d_reg <= in_s2_reg[0];
    end
  end
  wire pin_lvl  = in_s2_reg[2];
  wire ser_lvl  = in_s2_reg[1];
  wire bclk_ris = in_s2_reg[0] & ~bclk_d_reg;
  wire bclk_fal = ~in_s2_reg[0] & bclk_d_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0]  mode_reg;
  logic [15:0] brg_reg;
  logic [1:0]  dma_en_reg;
  logic [2:0]  txlvl_reg, rxlvl_reg;
  logic [4:0]  aud_reg;
  wire wr = reg_req.en & reg_req.wr;
  wire wr_mode = wr && reg_req.addr == sap_pkg::SAP_OFS_MODE;
  wire wr_brg  = wr && reg_req.addr == sap_pkg::SAP_OFS_BRG;
  wire wr_dma  = wr && reg_req.addr == sap_pkg::SAP_OFS_DMA;
  wire wr_aud  = wr && reg_req.addr == sap_pkg::SAP_OFS_AUD;
  wire tx_clr  = wr_dma & reg_req.wdata[sap_pkg::SAP_DMA_TXCLR];
  wire rx_clr  = wr_dma & reg_req.wdata[sap_pkg::SAP_DMA_RXCLR];
  wire aud_en  = aud_reg[sap_pkg::SAP_AUD_EN];
  wire mute    = aud_reg[sap_pkg::SAP_AUD_MUTE];
  wire pause   = aud_reg[sap_pkg::SAP_AUD_PAUSE];
  wire mono    = aud_reg[sap_pkg::SAP_AUD_MONO];
  wire justify = aud_reg[sap_pkg::SAP_AUD_JUST];
  wire pin_out = mode_reg[sap_pkg::SAP_MODE_SSIO] & master_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg   <= 2'h0;
      brg_reg    <= 16'h0000;
      dma_en_reg <= 2'h0;
      txlvl_reg  <= 3'h0;
      rxlvl_reg  <= 3'h0;
      aud_reg    <= 5'h00;
    end else if (ce) begin
      if (wr_mode) begin
        mode_reg <= reg_req.wdata[1:0];
      end
      if (wr_brg) begin
        brg_reg <= reg_req.wdata[sap_pkg::SAP_BRG_W-1:0];
      end
      if (wr_dma) begin
        dma_en_reg <= {reg_req.wdata[sap_pkg::SAP_DMA_RXEN],
                       reg_req.wdata[sap_pkg::SAP_DMA_TXEN]};
        txlvl_reg  <= reg_req.wdata[sap_pkg::SAP_DMA_TXLVL +: 3];
        rxlvl_reg  <= reg_req.wdata[sap_pkg::SAP_DMA_RXLVL +: 3];
      end
      if (wr_aud) begin
        aud_reg <= reg_req.wdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic [WORD-1:0] txm [DEPTH];
  logic [WORD-1:0] rxm [DEPTH];
  logic [2:0] txw_reg, txr_reg, rxw_reg, rxr_reg;
  logic [3:0] txc_reg, rxc_reg;
  logic       tx_take, rx_store;
  logic [WORD-1:0] rx_word;
  wire tx_wr = tx_push && txc_reg != 4'(DEPTH);
  wire tx_rd = tx_take && txc_reg != 4'h0 && !pause;
  wire rx_wr = rx_store && rxc_reg != 4'(DEPTH) && !pause;
  wire rx_rd = rx_pop && rxc_reg != 4'h0;
  always_ff @(posedge clk) begin
    if (ce && tx_wr) begin
      txm[txw_reg] <= tx_data;
    end
    if (ce && rx_wr) begin
      rxm[rxw_reg] <= rx_word;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txw_reg <= 3'h0;
      txr_reg <= 3'h0;
      txc_reg <= 4'h0;
      rxw_reg <= 3'h0;
      rxr_reg <= 3'h0;
      rxc_reg <= 4'h0;
    end else if (ce) begin
      if (tx_clr) begin
        txw_reg <= 3'h0;
        txr_reg <= 3'h0;
        txc_reg <= 4'h0;
      end else begin
        txw_reg <= txw_reg + 3'(tx_wr);
        txr_reg <= txr_reg + 3'(tx_rd);
        txc_reg <= txc_reg + 4'(tx_wr) - 4'(tx_rd);
      end
      if (rx_clr) begin
        rxw_reg <= 3'h0;
        rxr_reg <= 3'h0;
        rxc_reg <= 4'h0;
      end else begin
        rxw_reg <= rxw_reg + 3'(rx_wr);
        rxr_reg <= rxr_reg + 3'(rx_rd);
        rxc_reg <= rxc_reg + 4'(rx_wr) - 4'(rx_rd);
      end
    end
  end

  // ----------------------------------------------------------------
  // DMA requests
  // ----------------------------------------------------------------
  wire [3:0] tx_free = 4'(DEPTH) - txc_reg;
  wire tx_req_n = dma_en_reg[0] && tx_free >= {1'b0, txlvl_reg} + 4'h1;
  wire rx_req_n = dma_en_reg[1] && rxc_reg >= {1'b0, rxlvl_reg} + 4'h1;

  // ----------------------------------------------------------------
  // Serial engine and channel framing
  // ----------------------------------------------------------------
  sap_pkg::sap_state_t st_reg;
  logic [WORD-1:0] sh_reg, rs_reg, hold_reg;
  logic [4:0]      bit_reg, rbit_reg;
  logic            lr_reg, lr_out_reg, lag_reg;
  wire [4:0] last_bit = 5'(WORD - 1);
  wire [WORD-1:0] tx_head = mute ? '0 : txm[txr_reg];
  wire word_end = bclk_fal && bit_reg == last_bit;
  wire need_new = !aud_en || !mono || lr_reg;
  wire start_go = bclk_fal && st_reg == sap_pkg::SAP_IDLE && txc_reg != 4'h0 && !pause;
  assign tx_take  = (word_end && st_reg != sap_pkg::SAP_IDLE && need_new) || start_go;
  assign rx_store = bclk_ris && rbit_reg == last_bit &&
                    (!aud_en || !mono || !lr_reg);
  assign rx_word  = {rs_reg[WORD-2:0], ser_lvl};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= sap_pkg::SAP_IDLE;
      sh_reg     <= '0;
      rs_reg     <= '0;
      hold_reg   <= '0;
      bit_reg    <= 5'h00;
      rbit_reg   <= 5'h00;
      lr_reg     <= 1'b0;
      lr_out_reg <= 1'b0;
      lag_reg    <= 1'b0;
    end else if (ce) begin
      if (bclk_ris) begin
        rs_reg   <= rx_word;
        rbit_reg <= (rbit_reg == last_bit) ? 5'h00 : rbit_reg + 5'h01;
      end
      if (bclk_fal) begin
        lag_reg <= sh_reg[WORD-1];
        case (st_reg)
          sap_pkg::SAP_IDLE: begin
            if (start_go) begin
              st_reg   <= sap_pkg::SAP_LEFT;
              bit_reg  <= 5'h00;
              sh_reg   <= tx_head;
              hold_reg <= tx_head;
            end
          end
          default: begin
            if (bit_reg == last_bit) begin
              bit_reg  <= 5'h00;
              lr_reg   <= aud_en ? ~lr_reg : 1'b0;
              sh_reg   <= need_new ? tx_head : hold_reg;
              hold_reg <= need_new ? tx_head : hold_reg;
              st_reg   <= lr_reg ? sap_pkg::SAP_LEFT : sap_pkg::SAP_RIGHT;
            end else begin
              bit_reg <= bit_reg + 5'h01;
              sh_reg  <= {sh_reg[WORD-2:0], 1'b0};
            end
          end
        endcase
        lr_out_reg <= lr_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire sel_next = aud_en ? lr_reg : mode_reg[sap_pkg::SAP_MODE_SSV];
  wire ser_next = (aud_en && !justify) ? lag_reg : sh_reg[WORD-1];
  wire [31:0] rd_mode = {30'h0, mode_reg[sap_pkg::SAP_MODE_SSIO],
                         pin_out ? mode_reg[sap_pkg::SAP_MODE_SSV] : pin_lvl};
  wire [31:0] rd_dma = {dma_en_reg[1], 3'h0, rxc_reg, 4'h0, 1'b0, rxlvl_reg,
                        dma_en_reg[0], 3'h0, txc_reg, 4'h0, 1'b0, txlvl_reg};
  wire [31:0] rd_sel = (reg_req.addr == sap_pkg::SAP_OFS_MODE) ? rd_mode :
                       (reg_req.addr == sap_pkg::SAP_OFS_BRG)  ? {16'h0, brg_reg} :
                       (reg_req.addr == sap_pkg::SAP_OFS_DMA)  ? rd_dma :
                       (reg_req.addr == sap_pkg::SAP_OFS_AUD)  ? {27'h0, aud_reg} :
                       sap_pkg::SAP_RST_WORD;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata     <= sap_pkg::SAP_RST_WORD;
      rx_data       <= '0;
      ser_out       <= 1'b0;
      select_pin_o  <= 1'b0;
      select_pin_oe <= 1'b0;
      tx_dma_req    <= 1'b0;
      rx_dma_req    <= 1'b0;
    end else if (ce) begin
      reg_rdata     <= rd_sel;
      rx_data       <= rxm[rxr_reg];
      ser_out       <= ser_next;
      select_pin_o  <= sel_next;
      select_pin_oe <= pin_out;
      tx_dma_req    <= tx_req_n & ~(wr_dma & ~reg_req.wdata[sap_pkg::SAP_DMA_TXEN]);
      rx_dma_req    <= rx_req_n & ~(wr_dma & ~reg_req.wdata[sap_pkg::SAP_DMA_RXEN]);
    end
  end

endmodule : sap_top

// ---- verification/sap_chk.sv ----
// Checker: register port, DMA request and select pin relations of sap_top
// Assumes it is bound to sap_top and sees only its ports
`timescale 1ns/1ns
module sap_chk (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              ce,
  input wire sap_pkg::sap_req_t reg_req,
  input wire logic [31:0]       reg_rdata,
  input wire logic              master_en,
  input wire logic              tx_push,
  input wire logic              select_pin_oe,
  input wire logic              tx_dma_req,
  input wire logic              rx_dma_req
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [31:0] dma_reg, brg_reg, aud_reg;
  wire wr_go  = ce && reg_req.en && reg_req.wr;
  wire wr_dma = wr_go && reg_req.addr == sap_pkg::SAP_OFS_DMA;
  wire rd_dma = ce && reg_req.addr == sap_pkg::SAP_OFS_DMA;
  wire rd_brg = ce && !wr_go && reg_req.addr == sap_pkg::SAP_OFS_BRG;
  wire rd_aud = ce && !wr_go && reg_req.addr == sap_pkg::SAP_OFS_AUD;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_reg <= 32'h0;
      brg_reg <= 32'h0;
      aud_reg <= 32'h0;
    end else if (wr_go) begin
      if (reg_req.addr == sap_pkg::SAP_OFS_DMA) dma_reg <= reg_req.wdata;
      if (reg_req.addr == sap_pkg::SAP_OFS_BRG) brg_reg <= reg_req.wdata;
      if (reg_req.addr == sap_pkg::SAP_OFS_AUD) aud_reg <= reg_req.wdata;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence tx_clear_s; wr_dma && reg_req.wdata[4] && !tx_push; endsequence
  sequence dma_look_s; rd_dma && !tx_push; endsequence
  tx_clear_a: assert property (tx_clear_s ##1 dma_look_s |=> reg_rdata[11:8] == 4'h0)
    else $error("tx count not cleared");
  clr_read_a: assert property (rd_dma |=> !reg_rdata[20] && !reg_rdata[4])
    else $error("clear bit reads one");
  rx_drop_a: assert property (wr_dma && !reg_req.wdata[31] |=> !rx_dma_req)
    else $error("rx request not withdrawn");
  tx_drop_a: assert property (wr_dma && !reg_req.wdata[15] |=> !tx_dma_req)
    else $error("tx request not withdrawn");
  rx_gate_a: assert property (rx_dma_req |-> $past(dma_reg[31]))
    else $error("rx request while disabled");
  tx_gate_a: assert property (tx_dma_req |-> $past(dma_reg[15]))
    else $error("tx request while disabled");
  slave_oe_a: assert property (!master_en [*3] |-> !select_pin_oe)
    else $error("select pin driven in slave mode");
  unmap_rd_a: assert property (ce && reg_req.addr == 8'h04 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rate_rd_a: assert property (rd_brg |=> reg_rdata[15:0] == brg_reg[15:0])
    else $error("bit rate readback wrong");
  aud_rd_a: assert property (rd_aud |=> reg_rdata[4:0] == aud_reg[4:0])
    else $error("audio control readback wrong");
endmodule : sap_chk

bind sap_top sap_chk u_chk (.clk(clk), .nrst(nrst), .ce(ce), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .master_en(master_en), .tx_push(tx_push),
  .select_pin_oe(select_pin_oe), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

// ---- verification/sap_peer.sv ----
// Partner: serial peer that clocks one frame and swaps one word
// Assumes data leaves MSB first and bit clock idles low between frames
`timescale 1ns/1ns
module sap_peer (
  output logic      bit_clk,
  output logic      ser_in,
  input  wire logic ser_out
);
  logic [15:0] got;
  initial begin
    bit_clk = 1'b0;
    ser_in  = 1'b0;
    got     = 16'h0;
  end
  // One frame of 16 bit clocks at 48 ns
  task automatic frame(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      ser_in = w[i];
      #24 bit_clk = 1'b1;
      #24 got = {got[14:0], ser_out};
      bit_clk = 1'b0;
    end
    // Released line shows no stale level
    #24 ser_in = ~ser_in;
  endtask : frame
endmodule : sap_peer

// ---- verification/tb_top.sv ----
// Testbench: registers, DMA requests, select pin and framing of sap_top
// Assumes sap_peer as far end and sap_chk bound to the design
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // Signals and notes
  // ----------------------------------------------------------------
  typedef struct {string s; int k; logic [31:0] e, m;} sap_note_t;
  sap_note_t         q[$];
  sap_note_t         n;
  sap_pkg::sap_req_t req;
  logic              clk, nrst, look, master_en, tx_push, pin_ext;
  logic              ser_out, bit_clk, ser_in, pin_o, pin_oe, tx_req, rx_req;
  logic [15:0]       tx_data, rx_data;
  logic [31:0]       reg_rdata, r;
  logic [31:0]       obs [5];
  logic [7:0]        ofs [5] = '{8'h04, 8'h0C, 8'h14, 8'h18, 8'h1C};
  int                miscompares, num_checks, cyc;
  wire               pin_i = pin_oe ? pin_o : pin_ext;
  assign obs[0] = reg_rdata;
  assign obs[1] = {30'h0, rx_req, tx_req};
  assign obs[2] = {30'h0, pin_o, pin_oe};
  assign obs[3] = {16'h0, peer.got};
  assign obs[4] = {16'h0, rx_data};
  sap_top DUT (.clk(clk), .nrst(nrst), .ce(1'b1), .reg_req(req), .reg_rdata(reg_rdata),
    .master_en(master_en), .tx_push(tx_push), .tx_data(tx_data), .rx_data(rx_data),
    .rx_pop(1'b0), .bit_clk(bit_clk), .ser_in(ser_in), .ser_out(ser_out),
    .select_pin_i(pin_i), .select_pin_o(pin_o), .select_pin_oe(pin_oe),
    .tx_dma_req(tx_req), .rx_dma_req(rx_req));
  sap_peer peer (.bit_clk(bit_clk), .ser_in(ser_in), .ser_out(ser_out));
  always #2 clk = ~clk;
  // ----------------------------------------------------------------
  // Watcher and tasks
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (look && q.size() > 0) begin
      n = q.pop_front();
      num_checks++;
      if ((obs[n.k] & n.m) !== (n.e & n.m)) begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", n.s, n.e & n.m, obs[n.k] & n.m);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic see(input string s, input int k, input logic [31:0] e, m);
    q.push_back('{s, k, e, m});
    look <= 1'b1;
    @(posedge clk) look <= 1'b0;
  endtask : see
  task automatic pins(input string s, input int k, input logic [31:0] e, m);
    repeat (4) @(posedge clk);
    see(s, k, e, m);
  endtask : pins
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{1'b1, 1'b1, a, d};
    @(posedge clk) req.en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input string s);
    @(posedge clk) req <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge clk) req.en <= 1'b0;
    see(s, 0, e, m);
  endtask : rd
  task automatic push(input logic [15:0] d);
    @(posedge clk);
    tx_push <= 1'b1;
    tx_data <= d;
    @(posedge clk) tx_push <= 1'b0;
  endtask : push
  task automatic frame(input logic [15:0] w);
    @(posedge clk);
    #3 peer.frame(w);
    repeat (8) @(posedge clk);
  endtask : frame
  task automatic summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    look = 1'b0;
    master_en = 1'b0;
    tx_push = 1'b0;
    pin_ext = 1'b0;
    tx_data = 16'h0;
    req = '0;
    r = $urandom(75173);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], 32'h0, 32'hFFFF_FFFF, "reset value");
    r = $urandom_range(65535, 2);
    wr(8'h14, r);
    rd(8'h14, r, 32'h0000_FFFF, "bit rate");
    master_en <= 1'b1;
    r = $urandom;
    wr(8'h0C, {30'h0, 1'b1, r[0]});
    pins("select out", 2, {30'h0, r[0], 1'b1}, 32'h3);
    master_en <= 1'b0;
    pins("select in slave", 2, 32'h0, 32'h1);
    master_en <= 1'b1;
    wr(8'h0C, 32'h0);
    pin_ext <= ~r[0];
    pins("select dir in", 2, 32'h0, 32'h1);
    rd(8'h0C, {31'h0, ~r[0]}, 32'h1, "select level");
    wr(8'h18, 32'h0000_8007);
    pins("tx eight free", 1, 32'h1, 32'h3);
    wr(8'h18, 32'h0000_0007);
    pins("tx withdrawn", 1, 32'h0, 32'h1);
    wr(8'h18, 32'h0000_8003);
    repeat (4) push(16'($urandom));
    pins("tx four free", 1, 32'h1, 32'h1);
    push(16'($urandom));
    pins("tx three free", 1, 32'h0, 32'h1);
    wr(8'h18, 32'h0000_0003);
    rd(8'h18, 32'h0000_0500, 32'h0000_0F00, "tx count");
    wr(8'h18, 32'h0000_0010);
    rd(8'h18, 32'h0, 32'h0000_0F00, "tx cleared");
    wr(8'h18, 32'h8000_0000);
    r = $urandom;
    push({r[15:2], 2'b00});
    frame(r[31:16]);
    rd(8'h18, 32'h0100_0000, 32'h0F00_0F00, "counts after frame");
    see("rx word", 4, {16'h0, r[31:16]}, 32'hFFFF);
    pins("rx one entry", 1, 32'h2, 32'h2);
    wr(8'h18, 32'h0000_0000);
    pins("rx withdrawn", 1, 32'h0, 32'h2);
    wr(8'h18, 32'h8001_0000);
    pins("rx two entries", 1, 32'h0, 32'h2);
    wr(8'h18, 32'h0010_0000);
    rd(8'h18, 32'h0, 32'h0F00_0000, "rx cleared");
    wr(8'h1C, 32'h0000_0003);
    push(16'($urandom) | 16'h8001);
    frame(16'($urandom));
    see("muted word", 3, 32'h0, 32'hFFFF);
    wr(8'h18, 32'h0000_0010);
    wr(8'h1C, 32'h0000_001D);
    push(16'($urandom));
    frame(16'($urandom));
    rd(8'h18, 32'h0000_0100, 32'h0000_0F00, "paused tx count");
    rd(8'h1C, 32'h0000_001D, 32'h0000_001F, "audio control");
    summarize();
  end
endmodule : tb_top
